// file: rtl/resp_status_pkg.sv
// Purpose: constants for the card response and status word coder
// Assumes: one clock mclk at 125 MHz, synchronous active-high srst
// Notes: Avalon-MM register map and field codes live here
// Notes on behaviour
// - bit 7 of every byte is the msb; leftmost bit written is msb.
// - reserved bytes drive 00 and reserved bits drive zero.
// - status bit b3 set lets an invalidated file be read and updated.
// - structure code 00 transparent, 01 linear fixed, 03 cyclic.
// - type code 01 master, 02 dedicated, 04 elementary, 00 reserved.
// - access conditions sit in select response bytes 9 to 11, nibble each.
// - nibble 0 always, 1 first, 2 second, 3 reserved, 4-E admin, F never; the code grants F when the held level_q is F.
// - codes reused as admin levels still report their own nibble value.
// - plain normal ending answers 90 00.
// - pending proactive command answers 91 with its length.
// - failed data download answers 9E with response length.
// - waiting response data answers 9F with its length.
// - busy toolkit answers 93 00, later commands still accepted.
// - retried write answers 92 0X; memory fault answers 92 40.
// - referencing faults answer 94 with 00, 02, 04 or 08.
// - unmet access or failed check with attempts left answers 98 04.
// - 98 02 no secret, 98 08 secret state, 98 10 invalidation state.
// - failed check with no attempts left or blocked answers 98 40.
// - increase past maximum answers 98 50.
// - get-response only right after its command, else technical problem.
package resp_status_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FILE = 4'h1;
  localparam logic [3:0] REG_ACC_A = 4'h2;
  localparam logic [3:0] REG_ACC_B = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_STREAM = 4'h5;
  localparam logic [3:0] REG_SELRESP = 4'h6;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // ==========================================================
  // outcome codes written by software
  localparam logic [4:0] OC_NORMAL = 5'h00;
  localparam logic [4:0] OC_PROACTIVE = 5'h01;
  localparam logic [4:0] OC_DL_FAIL = 5'h02;
  localparam logic [4:0] OC_RESP_WAIT = 5'h03;
  localparam logic [4:0] OC_BUSY = 5'h04;
  localparam logic [4:0] OC_RETRY = 5'h05;
  localparam logic [4:0] OC_MEM_FAULT = 5'h06;
  localparam logic [4:0] OC_NO_EF = 5'h07;
  localparam logic [4:0] OC_BAD_ADDR = 5'h08;
  localparam logic [4:0] OC_NOT_FOUND = 5'h09;
  localparam logic [4:0] OC_INCONS = 5'h0A;
  localparam logic [4:0] OC_ACC_FAIL = 5'h0B;
  localparam logic [4:0] OC_NO_SECRET = 5'h0C;
  localparam logic [4:0] OC_SECRET_ST = 5'h0D;
  localparam logic [4:0] OC_INVAL_ST = 5'h0E;
  localparam logic [4:0] OC_BLOCKED = 5'h0F;
  localparam logic [4:0] OC_MAX_VAL = 5'h10;
  localparam logic [4:0] OC_GET_RESP = 5'h11;
  // ==========================================================
  // status bytes
  localparam logic [7:0] SB1_NORMAL = 8'h90;
  localparam logic [7:0] SB1_PROACTIVE = 8'h91;
  localparam logic [7:0] SB1_MEMORY = 8'h92;
  localparam logic [7:0] SB1_BUSY = 8'h93;
  localparam logic [7:0] SB1_REFER = 8'h94;
  localparam logic [7:0] SB1_SECURITY = 8'h98;
  localparam logic [7:0] SB1_DL_FAIL = 8'h9E;
  localparam logic [7:0] SB1_RESP_WAIT = 8'h9F;
  localparam logic [7:0] SB1_TECH = 8'h6F;
  localparam logic [7:0] SB2_NONE = 8'h00;
  localparam logic [7:0] SB2_BAD_ADDR = 8'h02;
  localparam logic [7:0] SB2_NOT_FOUND = 8'h04;
  localparam logic [7:0] SB2_INCONS = 8'h08;
  localparam logic [7:0] SB2_NO_SECRET = 8'h02;
  localparam logic [7:0] SB2_ACC_FAIL = 8'h04;
  localparam logic [7:0] SB2_SECRET_ST = 8'h08;
  localparam logic [7:0] SB2_INVAL_ST = 8'h10;
  localparam logic [7:0] SB2_MEM_FAULT = 8'h40;
  localparam logic [7:0] SB2_BLOCKED = 8'h40;
  localparam logic [7:0] SB2_MAX_VAL = 8'h50;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  // ==========================================================
  // file coding
  localparam logic [1:0] FS_TRANSPARENT = 2'h0;
  localparam logic [1:0] FS_LINEAR = 2'h1;
  localparam logic [1:0] FS_CYCLIC = 2'h2;
  localparam logic [7:0] STRUCT_TRANSPARENT = 8'h00;
  localparam logic [7:0] STRUCT_LINEAR = 8'h01;
  localparam logic [7:0] STRUCT_CYCLIC = 8'h03;
  localparam logic [1:0] FT_MASTER = 2'h0;
  localparam logic [1:0] FT_DEDICATED = 2'h1;
  localparam logic [1:0] FT_ELEMENTARY = 2'h2;
  localparam logic [7:0] TYPE_RESERVED = 8'h00;
  localparam logic [7:0] TYPE_MASTER = 8'h01;
  localparam logic [7:0] TYPE_DEDICATED = 8'h02;
  localparam logic [7:0] TYPE_ELEMENTARY = 8'h04;
  localparam int STAT_INVAL_OK_BIT = 2;
  localparam int STAT_VALID_BIT = 0;
  localparam logic [7:0] STAT_FIELD_MASK = 8'h05;
  localparam logic [3:0] AC_RESERVED = 4'h3;
  localparam logic [3:0] AC_ALWAYS = 4'h0;
  localparam logic [3:0] RETRY_MASK = 4'hF;
  localparam int ACC_NIBBLES = 6;
  localparam int SEL_BYTES = 5;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_SB1 = 2'b10,
    ST_SB2 = 2'b11
  } tx_state_e;
endpackage : resp_status_pkg

// file: rtl/card_response_status_coder.sv
// Purpose: status word and select response coder behind Avalon-MM
// Assumes: master holds requests until waitrequest low
// Notes: answers every access one cycle after it is raised
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module card_response_status_coder
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_status,
  output logic access_allowed
);
  import resp_status_pkg::*;

  // ==========================================================
  // bus handshake
  logic ack_q;
  logic rd_fire;
  logic wr_fire;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign rd_fire = avs_read & ack_q;
  assign wr_fire = avs_write & ack_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  // ==========================================================
  // control: outcome, counts, start
  logic [4:0] outcome_q;
  logic [7:0] len_q;
  logic [3:0] retry_q;
  logic [7:0] data_cnt_q;
  logic gr_ok_q;
  logic start;
  logic [7:0] stream_q [SEL_BYTES];
  logic [2:0] idx_q;
  assign start = wr_fire && avs_address == REG_CTRL && avs_byteenable[3];

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      outcome_q <= OC_NORMAL;
      len_q <= SB2_NONE;
      retry_q <= 4'h0;
      data_cnt_q <= 8'h00;
    end
    else if (wr_fire && avs_address == REG_CTRL)
    begin
      if (avs_byteenable[0])
        outcome_q <= avs_writedata[4:0];
      if (avs_byteenable[1])
        len_q <= avs_writedata[15:8];
      if (avs_byteenable[2])
      begin
        retry_q <= avs_writedata[19:16] & RETRY_MASK;
        data_cnt_q <= {5'h00, avs_writedata[23:21]};
      end
    end
  end

  // get-response is legal only right after a command that left data;
  // the master file is implicitly selected at activation, so it starts set
  always_ff @(posedge mclk)
  begin
    if (srst)
      gr_ok_q <= 1'b1;
    else if (start && !busy)
      gr_ok_q <= (outcome_q == OC_RESP_WAIT);
  end

  // ==========================================================
  // file descriptor and access nibbles
  logic [1:0] fstruct_q;
  logic [1:0] ftype_q;
  logic invalidated_q;
  logic inval_ok_q;
  logic [3:0] acc_q [ACC_NIBBLES];
  logic [2:0] acc_sel_q;
  logic [3:0] level_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      fstruct_q <= FS_TRANSPARENT;
      ftype_q <= FT_MASTER;
      invalidated_q <= 1'b0;
      inval_ok_q <= 1'b0;
      acc_sel_q <= 3'h0;
      level_q <= 4'h0;
    end
    else if (wr_fire && avs_address == REG_FILE)
    begin
      if (avs_byteenable[0])
      begin
        fstruct_q <= avs_writedata[1:0];
        ftype_q <= avs_writedata[3:2];
        invalidated_q <= avs_writedata[4];
        inval_ok_q <= avs_writedata[5];
      end
      if (avs_byteenable[1])
      begin
        acc_sel_q <= avs_writedata[10:8];
        level_q <= avs_writedata[15:12];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ACC_NIBBLES; gi++)
    begin : g_acc
      always_ff @(posedge mclk)
      begin
        if (srst)
          acc_q[gi] <= AC_ALWAYS;
        else if (wr_fire && avs_address == REG_ACC_A && avs_byteenable[gi/2])
          acc_q[gi] <= avs_writedata[gi*4 +: 4];
      end
    end
  endgenerate

  // the code is passed through unchanged, so a reused admin code reads back
  // as its own level; reserved nibble 3 never matches any held level
  logic [3:0] sel_cond;
  logic cond_met;
  always_comb
  begin
    sel_cond = (acc_sel_q < 3'(ACC_NIBBLES)) ? acc_q[acc_sel_q] : AC_RESERVED;
    cond_met = (sel_cond != AC_RESERVED) && (sel_cond == AC_ALWAYS
               || sel_cond == level_q);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      access_allowed <= 1'b0;
    else
      access_allowed <= cond_met && (!invalidated_q || inval_ok_q);
  end

  // ==========================================================
  // select response codes: structure, type, status; bytes 9..13 carry access, status, structure
  logic [7:0] struct_code;
  logic [7:0] type_code;
  logic [7:0] file_stat;
  always_comb
  begin
    case (fstruct_q)
      FS_LINEAR: struct_code = STRUCT_LINEAR;
      FS_CYCLIC: struct_code = STRUCT_CYCLIC;
      default: struct_code = STRUCT_TRANSPARENT;
    endcase
    case (ftype_q)
      FT_MASTER: type_code = TYPE_MASTER;
      FT_DEDICATED: type_code = TYPE_DEDICATED;
      FT_ELEMENTARY: type_code = TYPE_ELEMENTARY;
      default: type_code = TYPE_RESERVED;
    endcase
    file_stat = RESERVED_BYTE;
    file_stat[STAT_VALID_BIT] = ~invalidated_q;
    file_stat[STAT_INVAL_OK_BIT] = inval_ok_q;
    file_stat = file_stat & STAT_FIELD_MASK;
  end

  // ==========================================================
  // status word map
  logic [7:0] sb1;
  logic [7:0] sb2;
  always_comb
  begin
    sb2 = SB2_NONE;
    case (outcome_q)
      OC_NORMAL: sb1 = SB1_NORMAL;
      OC_PROACTIVE:
      begin
        sb1 = SB1_PROACTIVE;
        sb2 = len_q;
      end
      OC_DL_FAIL:
      begin
        sb1 = SB1_DL_FAIL;
        sb2 = len_q;
      end
      OC_RESP_WAIT:
      begin
        sb1 = SB1_RESP_WAIT;
        sb2 = len_q;
      end
      OC_BUSY: sb1 = SB1_BUSY;
      OC_RETRY:
      begin
        sb1 = SB1_MEMORY;
        sb2 = {4'h0, retry_q};
      end
      OC_MEM_FAULT:
      begin
        sb1 = SB1_MEMORY;
        sb2 = SB2_MEM_FAULT;
      end
      OC_NO_EF: sb1 = SB1_REFER;
      OC_BAD_ADDR:
      begin
        sb1 = SB1_REFER;
        sb2 = SB2_BAD_ADDR;
      end
      OC_NOT_FOUND:
      begin
        sb1 = SB1_REFER;
        sb2 = SB2_NOT_FOUND;
      end
      OC_INCONS:
      begin
        sb1 = SB1_REFER;
        sb2 = SB2_INCONS;
      end
      OC_ACC_FAIL:
      begin
        sb1 = SB1_SECURITY;
        sb2 = SB2_ACC_FAIL;
      end
      OC_NO_SECRET:
      begin
        sb1 = SB1_SECURITY;
        sb2 = SB2_NO_SECRET;
      end
      OC_SECRET_ST:
      begin
        sb1 = SB1_SECURITY;
        sb2 = SB2_SECRET_ST;
      end
      OC_INVAL_ST:
      begin
        sb1 = SB1_SECURITY;
        sb2 = SB2_INVAL_ST;
      end
      OC_BLOCKED:
      begin
        sb1 = SB1_SECURITY;
        sb2 = SB2_BLOCKED;
      end
      OC_MAX_VAL:
      begin
        sb1 = SB1_SECURITY;
        sb2 = SB2_MAX_VAL;
      end
      OC_GET_RESP:
        sb1 = gr_ok_q ? SB1_NORMAL : SB1_TECH;
      default: sb1 = SB1_TECH;
    endcase
  end

  // ==========================================================
  // byte sender: data bytes, then the two status bytes
  tx_state_e state_q;
  logic [7:0] left_q;
  logic [7:0] sb1_q;
  logic [7:0] sb2_q;
  logic busy;
  assign busy = (state_q != ST_IDLE);

  // stream bytes are the selection response bytes 9..13, msb first on wire
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < SEL_BYTES; i++)
        stream_q[i] <= RESERVED_BYTE;
    end
    else if (start && !busy)
    begin
      stream_q[0] <= {acc_q[1], acc_q[0]};
      stream_q[1] <= {acc_q[3], acc_q[2]};
      stream_q[2] <= {acc_q[5], acc_q[4]};
      stream_q[3] <= file_stat;
      stream_q[4] <= struct_code;
    end
  end

  // a start while busy is dropped; the busy status bit tells software
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      left_q <= 8'h00;
      idx_q <= 3'h0;
      sb1_q <= SB1_NORMAL;
      sb2_q <= SB2_NONE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start)
          begin
            sb1_q <= sb1;
            sb2_q <= sb2;
            idx_q <= 3'h0;
            left_q <= (data_cnt_q > 8'(SEL_BYTES)) ? 8'(SEL_BYTES)
                      : data_cnt_q;
            state_q <= (data_cnt_q != 8'h00) ? ST_DATA : ST_SB1;
          end
        ST_DATA:
          if (tx_ready)
          begin
            idx_q <= idx_q + 3'h1;
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01)
              state_q <= ST_SB1;
          end
        ST_SB1:
          if (tx_ready)
            state_q <= ST_SB2;
        ST_SB2:
          if (tx_ready)
            state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    tx_valid = busy;
    tx_status = (state_q == ST_SB1) || (state_q == ST_SB2);
    case (state_q)
      ST_DATA: tx_byte = stream_q[idx_q];
      ST_SB1: tx_byte = sb1_q;
      ST_SB2: tx_byte = sb2_q;
      default: tx_byte = RESERVED_BYTE;
    endcase
  end

  // ==========================================================
  // read data
  always_ff @(posedge mclk)
  begin
    if (srst)
      avs_readdata <= UNMAPPED_DATA;
    else if ((avs_read | avs_write) & ~ack_q)
    begin
      case (avs_address)
        REG_CTRL: avs_readdata <= {8'h00, data_cnt_q[2:0], 1'b0, retry_q,
                                   len_q, 3'h0, outcome_q};
        REG_FILE: avs_readdata <= {16'h0000, level_q, 1'b0, acc_sel_q,
                                   2'h0, inval_ok_q, invalidated_q,
                                   ftype_q, fstruct_q};
        REG_ACC_A: avs_readdata <= {8'h00, acc_q[5], acc_q[4], acc_q[3],
                                    acc_q[2], acc_q[1], acc_q[0]};
        REG_STAT: avs_readdata <= {26'h0000000, gr_ok_q, access_allowed,
                                   state_q, 1'b0, busy};
        REG_STREAM: avs_readdata <= {sb1_q, sb2_q, 16'h0000};
        REG_SELRESP: avs_readdata <= {type_code, struct_code, file_stat,
                                      RESERVED_BYTE};
        default: avs_readdata <= UNMAPPED_DATA;
      endcase
    end
  end
endmodule : card_response_status_coder

// file: tb/coder_sva.sv
// Purpose: port checker for the status coder
// Assumes: one clock, srst synchronous active high
// Notes: sees only the top module ports
`timescale 1ns/1ps
module coder_sva
  import resp_status_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_status,
  input wire logic access_allowed
);
  // ==========================================================
  // helper: status bytes taken so far in this frame
  logic [1:0] st_cnt_q;
  logic req;
  logic st_acc;
  logic sb1_acc;
  assign req = avs_read || avs_write;
  assign st_acc = tx_valid && tx_ready && tx_status;
  assign sb1_acc = st_acc && (st_cnt_q == 2'h0);
  always_ff @(posedge mclk)
  begin
    if (srst || !tx_valid)
      st_cnt_q <= 2'h0;
    else if (st_acc)
      st_cnt_q <= st_cnt_q + 2'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================================
  // properties
  sequence s_ack;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_wait_one: assert property ($rose(req) |-> s_ack)
    else $error("bus answer not one cycle after request");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte) && $stable(tx_status))
    else $error("stalled byte changed");
  a_second_status: assert property (
    sb1_acc |=> tx_valid && tx_status)
    else $error("second status byte missing");
  a_frame_end: assert property (
    st_acc && st_cnt_q == 2'h1 |=> !tx_valid)
    else $error("bytes after second status byte");
  a_data_follow: assert property (
    tx_valid && tx_ready && !tx_status |=> tx_valid)
    else $error("frame ended after a data byte");
  a_sb1_range: assert property (
    sb1_acc |-> tx_byte[7:4] == 4'h9 || tx_byte == SB1_TECH)
    else $error("first status byte out of range");
  a_normal_pair: assert property (
    sb1_acc && tx_byte == SB1_NORMAL |=> tx_byte == SB2_NONE)
    else $error("normal ending second byte wrong");
  a_busy_pair: assert property (
    sb1_acc && tx_byte == SB1_BUSY |=> tx_byte == 8'h00)
    else $error("busy second byte wrong");
  a_refer_codes: assert property (
    sb1_acc && tx_byte == SB1_REFER |=>
    tx_byte inside {8'h00, 8'h02, 8'h04, 8'h08})
    else $error("referencing second byte wrong");
  a_security_codes: assert property (
    sb1_acc && tx_byte == SB1_SECURITY |=>
    tx_byte inside {8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h50})
    else $error("security second byte wrong");
  a_memory_codes: assert property (
    sb1_acc && tx_byte == SB1_MEMORY |=>
    tx_byte[7:4] == 4'h0 || tx_byte == SB2_MEM_FAULT)
    else $error("memory second byte wrong");
endmodule : coder_sva

bind card_response_status_coder coder_sva u_coder_sva (.mclk(mclk),
  .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_status(tx_status),
  .access_allowed(access_allowed));

// file: tb/terminal_sink.sv
// Purpose: terminal side sink for the coder byte stream
// Assumes: a byte is taken on an edge with valid and ready high
// Notes: slow mode offers ready on alternate cycles only
`timescale 1ns/1ps
module terminal_sink
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_status,
  input wire logic slow,
  output logic tx_ready
);
  // ==========================================================
  // byte log, bit 8 marks a status byte
  logic [8:0] log_q[$];
  logic tog_q;
  always_ff @(posedge mclk)
  begin
    if (srst)
      tog_q <= 1'b0;
    else
      tog_q <= !tog_q;
  end
  assign tx_ready = !srst && (!slow || tog_q);
  // secrets go out as eight digit bytes, msb clear, short ones FF padded
  function automatic logic [63:0] secret_field(input int n);
    logic [63:0] f;
    f = 64'hFFFF_FFFF_FFFF_FFFF;
    for (int i = 0; i < 8; i++)
    begin
      if (i < n)
        f[63 - 8 * i -: 8] = 8'h31 + 8'(i);
    end
    return f;
  endfunction : secret_field
  // bytes kept as sent, bit 7 is the msb b8
  // no decision is taken on reserved bits
  always @(posedge mclk)
  begin
    if (!srst && tx_valid && tx_ready)
      log_q.push_back({tx_status, tx_byte});
  end
endmodule : terminal_sink

// file: tb/testbench.sv
// Purpose: self-checking bench for the status coder
// Assumes: bus requests stand until waitrequest is sampled low
// Notes: fixed stimulus, slow sink stalls the byte stream
`timescale 1ns/1ps
module testbench;
  import resp_status_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_ready;
  logic tx_status;
  logic access_allowed;
  logic slow = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  // reset counts as a command that left response data waiting
  int last_oc = 3;
  always #4 mclk = ~mclk;
  card_response_status_coder u_card_response_status_coder (.mclk(mclk),
    .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_status(tx_status),
    .access_allowed(access_allowed));
  terminal_sink u_terminal_sink (.mclk(mclk), .srst(srst),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_status(tx_status),
    .slow(slow), .tx_ready(tx_ready));
  // ==========================================================
  // common tasks
  task automatic stop_test();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic check_word(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : check_word
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
      bad_count++;
  endtask : bus
  function automatic logic [15:0] exp_sw(input int oc,
    input logic [7:0] len, input logic [3:0] rt);
    case (oc)
      0: return 16'h9000;
      1: return {8'h91, len};
      2: return {8'h9E, len};
      3: return {8'h9F, len};
      4: return 16'h9300;
      5: return {12'h920, rt};
      6: return 16'h9240;
      7: return 16'h9400;
      8: return 16'h9402;
      9: return 16'h9404;
      10: return 16'h9408;
      11: return 16'h9804;
      12: return 16'h9802;
      13: return 16'h9808;
      14: return 16'h9810;
      15: return 16'h9840;
      16: return 16'h9850;
      17: return (last_oc == 3) ? 16'h9000 : 16'h6F00;
      default: return 16'h6F00;
    endcase
  endfunction : exp_sw
  // outcome written first, start in a second write
  task automatic run_cmd(input int oc, input logic [7:0] len,
    input logic [3:0] rt, input logic [2:0] cnt, input int nd,
    input logic [39:0] dat);
    logic [31:0] rd;
    logic [15:0] sw;
    logic [8:0] e;
    int k;
    k = 0;
    sw = exp_sw(oc, len, rt);
    last_oc = oc;
    u_terminal_sink.log_q.delete();
    bus(1'b1, REG_CTRL, {8'h00, cnt, 1'b0, rt, len, 3'h0, oc[4:0]}, 4'h7, rd);
    bus(1'b1, REG_CTRL, 32'h0, 4'h8, rd);
    while (u_terminal_sink.log_q.size() < nd + 2 && k < 200)
    begin
      @(posedge mclk);
      k++;
    end
    repeat (6) @(posedge mclk);
    check_word("frame size", nd + 2, u_terminal_sink.log_q.size());
    for (int i = 0; i < nd + 2 && i < u_terminal_sink.log_q.size(); i++)
    begin
      e = (i < nd) ? {1'b0, dat[8 * (4 - i) +: 8]} :
        (i == nd) ? {1'b1, sw[15:8]} : {1'b1, sw[7:0]};
      check_word("tx byte", e, u_terminal_sink.log_q[i]);
    end
    bus(1'b0, REG_STREAM, 32'h0, 4'hF, rd);
    check_word("stream", {sw, 16'h0000}, rd);
  endtask : run_cmd
  // ==========================================================
  // scenarios
  task automatic test_reset();
    logic [31:0] rd;
    bus(1'b0, REG_CTRL, 32'h0, 4'hF, rd);
    check_word("ctrl", 32'h0, rd);
    bus(1'b0, REG_ACC_A, 32'h0, 4'hF, rd);
    check_word("acc", 32'h0, rd);
    bus(1'b1, 4'hF, 32'hFFFF_FFFF, 4'hF, rd);
    bus(1'b0, 4'hF, 32'h0, 4'hF, rd);
    check_word("unmapped", UNMAPPED_DATA, rd);
    check_word("access", 1'b1, access_allowed);
  endtask : test_reset
  task automatic test_access();
    logic [31:0] rd;
    bus(1'b1, REG_FILE, 32'h30, 4'hF, rd);
    repeat (3) @(negedge mclk);
    check_word("access", 1'b1, access_allowed);
    bus(1'b1, REG_FILE, 32'h10, 4'hF, rd);
    repeat (3) @(negedge mclk);
    check_word("access", 1'b0, access_allowed);
    bus(1'b1, REG_FILE, 32'h0, 4'hF, rd);
    bus(1'b1, REG_ACC_A, 32'hF, 4'hF, rd);
    repeat (3) @(negedge mclk);
    check_word("access", 1'b0, access_allowed);
    bus(1'b1, REG_FILE, 32'h5100, 4'hF, rd);
    bus(1'b1, REG_ACC_A, 32'h50, 4'hF, rd);
    repeat (3) @(negedge mclk);
    check_word("access", 1'b1, access_allowed);
    bus(1'b1, REG_FILE, 32'h3100, 4'hF, rd);
    bus(1'b1, REG_ACC_A, 32'h30, 4'hF, rd);
    repeat (3) @(negedge mclk);
    check_word("access", 1'b0, access_allowed);
  endtask : test_access
  task automatic test_codes();
    for (int c = 0; c <= 17; c++)
    begin
      slow <= c[0];
      run_cmd(c, 8'h5A, 4'h7, 3'h0, 0, 40'h0);
    end
    run_cmd(5, 8'h00, 4'hF, 3'h0, 0, 40'h0);
    run_cmd(3, 8'h10, 4'h0, 3'h0, 0, 40'h0);
    run_cmd(17, 8'h00, 4'h0, 3'h0, 0, 40'h0);
    run_cmd(31, 8'h00, 4'h0, 3'h0, 0, 40'h0);
  endtask : test_codes
  task automatic test_stream();
    logic [31:0] rd;
    logic [7:0] sc;
    logic [7:0] tc;
    slow <= 1'b1;
    bus(1'b1, REG_ACC_A, 32'h00F1_F1F1, 4'hF, rd);
    for (int s = 0; s < 4; s++)
    begin
      sc = (s == 2) ? 8'h03 : (s == 3) ? 8'h00 : s[7:0];
      tc = (s == 3) ? 8'h00 : 8'h01 << s;
      bus(1'b1, REG_FILE, {26'h0, 2'h3, s[1:0], s[1:0]}, 4'hF, rd);
      bus(1'b0, REG_SELRESP, 32'h0, 4'hF, rd);
      check_word("selresp", {tc, sc, 8'h04, 8'h00}, rd);
      run_cmd(0, 8'h00, 4'h0, 3'h7, 5,
        {24'hF1F1F1, 8'h04, sc});
    end
  endtask : test_stream
  task automatic test_secret();
    logic [63:0] f;
    f = u_terminal_sink.secret_field(4);
    check_word("secret digits", 32'h3132_3334, f[63:32]);
    check_word("secret pad", 32'hFFFF_FFFF, f[31:0]);
    f = u_terminal_sink.secret_field(8);
    check_word("unlock digits", 32'h3536_3738, f[31:0]);
  endtask : test_secret
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    test_reset();
    test_access();
    test_codes();
    test_stream();
    test_secret();
    stop_test();
  end
  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule : testbench
